/* rtl/rcr_top.v */
// reset cause recorder with ahb-lite register slave
//
// Behaviour
// - pin or power-on-clear reset clears the watchdog reset flag.
// - watchdog reset sets watchdog flag; low-voltage reset leaves it held.
// - low-voltage reset sets low-voltage flag; watchdog reset leaves it held.
// - detect control cleared by pin, power-on-clear, watchdog; held on low-voltage.
// - reset cause flags read 00h after reset, contents depend on source.
// - detect control reads 00h after reset, subject to source retention.
// - level select reads 00h after reset, value depends on source.
// - during reset or oscillator wait only program counter is invalid.
// - reading reset cause flags clears them; pin and power-on-clear too.
// - watchdog flag at bit 4, low-voltage flag at bit 0, others zero.
`timescale 1ns/1ps
`include "rcr_defs.vh"
module rcr_top (
  input wire I_CLK, // system clock, 200 mhz
  input wire I_ARST_N, // power-up reset, async, active low
  input wire I_CE, // clock enable, freezes all state when low
  input wire I_RST_PIN_N, // external reset pin, active low
  input wire I_POC_REQ, // power-on-clear reset request, high
  input wire I_WDT_REQ, // watchdog timer reset request, high
  input wire I_LVD_REQ, // low-voltage detector reset request, high
  input wire I_HSEL, // ahb slave select
  input wire [7:0] I_HADDR, // ahb address, low byte
  input wire [1:0] I_HTRANS, // ahb transfer type
  input wire I_HWRITE, // ahb write
  input wire [2:0] I_HSIZE, // ahb size, word only
  input wire [31:0] I_HWDATA, // ahb write data
  input wire I_HREADY, // ahb bus ready
  output wire [31:0] O_HRDATA, // ahb read data
  output wire O_HREADYOUT, // ahb slave ready
  output wire O_HRESP, // ahb response, always okay
  output wire O_IRQ, // level interrupt, high
  output wire [7:0] O_LVD_CTRL, // low-voltage detect control
  output wire [7:0] O_LVD_LEVEL, // low-voltage level select
  output wire O_PC_VALID, // program counter defined
  output wire O_IN_RESET // a reset request is active
);

  //////////////////////////////////////////////////////////////////////
  // declarations
  wire [`RCR_NSRC-1:0] req_raw;
  wire [`RCR_NSRC-1:0] req_f;
  reg [`RCR_NSRC-1:0] req_prev_reg;
  wire [`RCR_NSRC-1:0] evt;
  wire clr_evt;
  wire in_reset;

  reg [7:0] cause_reg;
  reg [7:0] cause_next;
  reg [7:0] lvctl_reg;
  reg [7:0] lvctl_next;
  reg [7:0] lvsel_reg;
  reg [7:0] lvsel_next;
  reg [3:0] irqst_reg;
  reg [3:0] irqst_next;
  reg [3:0] irqmk_reg;
  reg [3:0] irqmk_next;
  reg [2:0] last_reg;
  reg [2:0] last_next;
  reg [`RCR_WAIT_W-1:0] wait_reg;
  reg [`RCR_WAIT_W-1:0] wait_next;
  reg pc_valid_reg;
  reg in_reset_reg;
  reg irq_reg;

  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [31:0] hrdata_reg;
  reg [31:0] hrdata_next;
  reg hreadyout_reg;

  wire addr_valid;
  wire rd_take;
  wire wr_take;
  wire rd_cause;
  wire rd_irqst;
  wire wr_now;
  wire [7:0] wdata8;

  // the count is worked out as an integer; keep only the counter's width
  localparam integer WAIT_INT = `RCR_OSC_WAIT_CYC;
  localparam [`RCR_WAIT_W-1:0] WAIT_CYC = WAIT_INT[`RCR_WAIT_W-1:0];

  //////////////////////////////////////////////////////////////////////
  // request lines come from outside the domain: synchronise and filter
  assign req_raw[`RCR_SRC_PIN] = ~I_RST_PIN_N;
  assign req_raw[`RCR_SRC_POC] = I_POC_REQ;
  assign req_raw[`RCR_SRC_WDT] = I_WDT_REQ;
  assign req_raw[`RCR_SRC_LVD] = I_LVD_REQ;

  rcr_sync #(
    .W(`RCR_NSRC)
  ) u_sync (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_async(req_raw),
    .o_sync(req_f)
  );

  // previous filtered level for edge detection
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      req_prev_reg <= {`RCR_NSRC{1'b0}};
    end else if (I_CE) begin
      req_prev_reg <= req_f;
    end
  end

  // an event is the assertion of a filtered request
  assign evt = req_f & ~req_prev_reg;
  // sources that wipe the whole cause record
  assign clr_evt = evt[`RCR_SRC_PIN] | evt[`RCR_SRC_POC];
  assign in_reset = |req_f;

  //////////////////////////////////////////////////////////////////////
  // ahb-lite address phase decode
  assign addr_valid = I_HSEL & I_HREADY & I_HTRANS[1];
  assign rd_take = addr_valid & ~I_HWRITE;
  assign wr_take = addr_valid & I_HWRITE;
  assign rd_cause = rd_take & (I_HADDR == `RCR_OFS_CAUSE);
  assign rd_irqst = rd_take & (I_HADDR == `RCR_OFS_IRQST);
  // write data arrives one cycle after the address phase
  assign wr_now = wr_pend_reg;
  assign wdata8 = I_HWDATA[7:0];

  // write pending flag and latched address
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (I_CE) begin
      if (I_HREADY) begin
        wr_pend_reg <= wr_take;
        wr_addr_reg <= I_HADDR;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux, loaded in the address phase so data stands zero-wait
  always @* begin
    hrdata_next = hrdata_reg;
    if (rd_take) begin
      case (I_HADDR)
        `RCR_OFS_CAUSE: hrdata_next = {24'h000000, cause_reg};
        `RCR_OFS_LVCTL: hrdata_next = {24'h000000, lvctl_reg};
        `RCR_OFS_LVSEL: hrdata_next = {24'h000000, lvsel_reg};
        `RCR_OFS_IRQST: hrdata_next = {28'h0000000, irqst_reg};
        `RCR_OFS_IRQMK: hrdata_next = {28'h0000000, irqmk_reg};
        `RCR_OFS_STAT: hrdata_next = {29'h0, wait_reg != 8'h00,
          pc_valid_reg, in_reset_reg};
        `RCR_OFS_LAST: hrdata_next = {29'h0, last_reg};
        default: hrdata_next = 32'h00000000;
      endcase
    end
  end

  // bus outputs from flops; this slave never inserts wait states
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
    end else if (I_CE) begin
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // reset cause flags: per-source update, hardware set beats read clear
  always @* begin
    cause_next = cause_reg;
    // software read returns the value then clears it
    if (rd_cause) begin
      cause_next = 8'h00;
    end
    // pin or power-on-clear wipes the record first
    if (clr_evt) begin
      cause_next = 8'h00;
    end
    // watchdog sets its flag and holds the low-voltage flag
    if (evt[`RCR_SRC_WDT] && !clr_evt) begin
      cause_next[`RCR_BIT_WDT_FLAG] = 1'b1;
    end
    // low-voltage sets its flag and holds the watchdog flag
    if (evt[`RCR_SRC_LVD] && !clr_evt) begin
      cause_next[`RCR_BIT_LVD_FLAG] = 1'b1;
    end
    // only the two flag positions can ever be one
    cause_next = cause_next & ((8'h01 << `RCR_BIT_WDT_FLAG) |
      (8'h01 << `RCR_BIT_LVD_FLAG));
  end

  //////////////////////////////////////////////////////////////////////
  // detector control and level: cleared by all but a low-voltage reset
  always @* begin
    lvctl_next = lvctl_reg;
    lvsel_next = lvsel_reg;
    // writes are ignored while a reset is held; cpu is not running then
    if (wr_now && !in_reset) begin
      if (wr_addr_reg == `RCR_OFS_LVCTL) begin
        lvctl_next = wdata8;
      end
      if (wr_addr_reg == `RCR_OFS_LVSEL) begin
        lvsel_next = wdata8;
      end
    end
    // the detector must not reset its own setup, or it could not rearm
    if (clr_evt || evt[`RCR_SRC_WDT]) begin
      lvctl_next = `RCR_RST_LVCTL;
      lvsel_next = `RCR_RST_LVSEL;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // last cause code, for software that wants a single answer
  always @* begin
    last_next = last_reg;
    if (evt[`RCR_SRC_LVD]) begin
      last_next = `RCR_LAST_LVD;
    end
    if (evt[`RCR_SRC_WDT]) begin
      last_next = `RCR_LAST_WDT;
    end
    if (evt[`RCR_SRC_POC]) begin
      last_next = `RCR_LAST_POC;
    end
    if (evt[`RCR_SRC_PIN]) begin
      last_next = `RCR_LAST_PIN;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt status: sticky events, read clears, set wins
  always @* begin
    irqst_next = irqst_reg;
    irqmk_next = irqmk_reg;
    if (rd_irqst) begin
      irqst_next = 4'h0;
    end
    irqst_next = irqst_next | evt;
    if (wr_now && (wr_addr_reg == `RCR_OFS_IRQMK)) begin
      irqmk_next = I_HWDATA[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // oscillation wait: reloads while any request is held
  always @* begin
    wait_next = wait_reg;
    if (in_reset) begin
      wait_next = WAIT_CYC;
    end else if (wait_reg != 8'h00) begin
      wait_next = wait_reg - 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state flops; power-up reset gives the documented after-reset values
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cause_reg <= `RCR_RST_CAUSE;
      lvctl_reg <= `RCR_RST_LVCTL;
      lvsel_reg <= `RCR_RST_LVSEL;
      irqst_reg <= 4'h0;
      irqmk_reg <= `RCR_RST_IRQMK;
      last_reg <= `RCR_LAST_NONE;
      wait_reg <= 8'h00;
    end else if (I_CE) begin
      cause_reg <= cause_next;
      lvctl_reg <= lvctl_next;
      lvsel_reg <= lvsel_next;
      irqst_reg <= irqst_next;
      irqmk_reg <= irqmk_next;
      last_reg <= last_next;
      wait_reg <= wait_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered status and interrupt outputs
  // only the program counter is flagged invalid; all else holds
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pc_valid_reg <= 1'b0;
      in_reset_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (I_CE) begin
      pc_valid_reg <= !in_reset && (wait_next == 8'h00);
      in_reset_reg <= in_reset;
      irq_reg <= |(irqst_next & irqmk_next);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign O_HRDATA = hrdata_reg;
  assign O_HREADYOUT = hreadyout_reg;
  assign O_HRESP = `RCR_HRESP_OKAY;
  assign O_IRQ = irq_reg;
  assign O_LVD_CTRL = lvctl_reg;
  assign O_LVD_LEVEL = lvsel_reg;
  assign O_PC_VALID = pc_valid_reg;
  assign O_IN_RESET = in_reset_reg;

endmodule // rcr_top

/* shared/rcr_defs.vh */
// constants for the reset cause recorder
`ifndef RCR_DEFS_VH
`define RCR_DEFS_VH

// register byte offsets on the ahb-lite bus
`define RCR_OFS_CAUSE 8'h00
`define RCR_OFS_LVCTL 8'h04
`define RCR_OFS_LVSEL 8'h08
`define RCR_OFS_IRQST 8'h0c
`define RCR_OFS_IRQMK 8'h10
`define RCR_OFS_STAT 8'h14
`define RCR_OFS_LAST 8'h18

// field positions in the reset cause flags register
`define RCR_BIT_WDT_FLAG 4
`define RCR_BIT_LVD_FLAG 0

// source index in the request and event vectors
`define RCR_SRC_PIN 0
`define RCR_SRC_POC 1
`define RCR_SRC_WDT 2
`define RCR_SRC_LVD 3
`define RCR_NSRC 4

// last-cause codes
`define RCR_LAST_NONE 3'h0
`define RCR_LAST_PIN 3'h1
`define RCR_LAST_POC 3'h2
`define RCR_LAST_WDT 3'h3
`define RCR_LAST_LVD 3'h4

// reset values
`define RCR_RST_CAUSE 8'h00
`define RCR_RST_LVCTL 8'h00
`define RCR_RST_LVSEL 8'h00
`define RCR_RST_IRQMK 4'h0

// status register bits
`define RCR_BIT_IN_RESET 0
`define RCR_BIT_PC_VALID 1
`define RCR_BIT_OSC_WAIT 2

// oscillation stabilisation wait after the last request drops
`define RCR_CLK_MHZ 200
`define RCR_OSC_WAIT_NS 100
`define RCR_OSC_WAIT_CYC ((`RCR_OSC_WAIT_NS * `RCR_CLK_MHZ + 999) / 1000)
`define RCR_WAIT_W 8

// ahb encodings
`define RCR_HTRANS_NONSEQ 2'h2
`define RCR_HTRANS_SEQ 2'h3
`define RCR_HRESP_OKAY 1'h0

`endif

/* rtl/rcr_sync.v */
// three-stage synchroniser with agreement filter for request lines
`timescale 1ns/1ps
module rcr_sync #(
  parameter W = 4
) (
  input wire i_clk, // system clock
  input wire i_arst_n, // async reset, active low
  input wire i_ce, // clock enable
  input wire [W-1:0] i_async, // raw lines from outside the domain
  output wire [W-1:0] o_sync // filtered, synchronous lines
);

  //////////////////////////////////////////////////////////////////////
  // one chain per line; stage 1 feeds only stage 2
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_line
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg out_reg;
      // a change counts only once stages 2 and 3 agree
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          out_reg <= 1'b0;
        end else if (i_ce) begin
          s1_reg <= i_async[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign o_sync[g] = out_reg;
    end
  endgenerate

endmodule // rcr_sync

/* testbench/rcr_ahb_master.sv */
// bus master standing in for cpu software on the register bus
`timescale 1ns/1ps
module rcr_ahb_master (
  input wire logic i_clk, // bus clock
  input wire logic i_hready, // bus ready
  input wire logic [31:0] i_hrdata, // read data
  output logic o_hsel, // select
  output logic o_hwrite, // write
  output logic [1:0] o_htrans, // transfer type
  output logic [2:0] o_hsize, // always a word
  output logic [7:0] o_haddr, // byte address
  output logic [31:0] o_hwdata // write data
);
  // idle at time zero so nothing is taken during reset
  initial begin
    o_hsel = 1'b0;
    o_hwrite = 1'b0;
    o_htrans = 2'h0;
    o_hsize = 3'h2;
    o_haddr = 8'h00;
    o_hwdata = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // one single transfer; no wait count is assumed, ready decides
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] v, output logic [31:0] d);
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_hwrite <= w;
    o_htrans <= 2'h2;
    @(posedge i_clk);
    while (i_hready !== 1'b1)
      @(posedge i_clk);
    o_htrans <= 2'h0;
    o_hwdata <= v;
    @(posedge i_clk);
    while (i_hready !== 1'b1)
      @(posedge i_clk);
    d = i_hrdata;
  endtask
endmodule // rcr_ahb_master

/* testbench/rcr_sva.sv */
// port checker for the reset cause recorder
`timescale 1ns/1ps
module rcr_sva (
  input wire logic I_CLK, // clock
  input wire logic I_ARST_N, // reset
  input wire logic I_HSEL, // select
  input wire logic I_HREADY, // ready
  input wire logic I_HWRITE, // write
  input wire logic [1:0] I_HTRANS, // type
  input wire logic [7:0] I_HADDR, // address
  input wire logic I_WDT_REQ, // watchdog
  input wire logic I_LVD_REQ, // low volts
  input wire logic [31:0] O_HRDATA, // data
  input wire logic [7:0] O_LVD_CTRL, // control
  input wire logic [7:0] O_LVD_LEVEL, // level
  input wire logic O_PC_VALID, // pc ok
  input wire logic O_IN_RESET // in reset
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  //////////////////////////////////////////////////////////////////////
  // address phase of a cause register read
  wire rd_cause = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE
    && I_HADDR == 8'h00;
  property p_zero;
    rd_cause |=> (O_HRDATA & 32'hffffffee) == 32'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("cause spare bits set");
  // a watchdog event lands about five edges after the raw rise
  property p_wctl;
    $rose(I_WDT_REQ) |-> ##[4:7] O_LVD_CTRL == 8'h00;
  endproperty
  a_wctl: assert property (p_wctl)
    else $error("control kept on watchdog");
  property p_wlvl;
    $rose(I_WDT_REQ) |-> ##[4:7] O_LVD_LEVEL == 8'h00;
  endproperty
  a_wlvl: assert property (p_wlvl)
    else $error("level kept on watchdog");
  property p_hctl;
    $rose(I_LVD_REQ) && !I_WDT_REQ |-> ##2 $stable(O_LVD_CTRL) [*6];
  endproperty
  a_hctl: assert property (p_hctl)
    else $error("control lost on low volts");
  property p_hlvl;
    $rose(I_LVD_REQ) && !I_WDT_REQ |-> ##2 $stable(O_LVD_LEVEL) [*6];
  endproperty
  a_hlvl: assert property (p_hlvl)
    else $error("level lost on low volts");
  property p_pcl;
    O_IN_RESET |=> !O_PC_VALID;
  endproperty
  a_pcl: assert property (p_pcl)
    else $error("pc valid in reset");
  property p_osc;
    $fell(O_IN_RESET) |-> !O_PC_VALID [*8];
  endproperty
  a_osc: assert property (p_osc)
    else $error("pc valid in osc wait");
  property p_pcup;
    $fell(O_IN_RESET) |-> ##[18:23] O_PC_VALID;
  endproperty
  a_pcup: assert property (p_pcup)
    else $error("pc stays invalid");
  property p_inr;
    $rose(I_WDT_REQ) |-> ##[3:7] O_IN_RESET;
  endproperty
  a_inr: assert property (p_inr)
    else $error("reset not flagged");
  c_rd: cover property (rd_cause);
  c_inr: cover property ($rose(O_IN_RESET));
  c_pc: cover property ($rose(O_PC_VALID));
endmodule // rcr_sva
bind rcr_top rcr_sva u_sva (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
  .I_HSEL(I_HSEL), .I_HREADY(I_HREADY), .I_HWRITE(I_HWRITE),
  .I_HTRANS(I_HTRANS), .I_HADDR(I_HADDR), .I_WDT_REQ(I_WDT_REQ),
  .I_LVD_REQ(I_LVD_REQ), .O_HRDATA(O_HRDATA), .O_LVD_CTRL(O_LVD_CTRL),
  .O_LVD_LEVEL(O_LVD_LEVEL), .O_PC_VALID(O_PC_VALID),
  .O_IN_RESET(O_IN_RESET));

/* testbench/reset_cause_recorder_bench.sv */
// self-checking bench for the reset cause recorder
`timescale 1ns/1ps
module reset_cause_recorder_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] req = 4'h0;
  int miscompares = 0;
  int checks_done = 0;
  wire sel, wen, rdy, resp, irq, pcv, inr;
  wire [1:0] tr;
  wire [2:0] sz;
  wire [7:0] ad, ctl, lvl;
  wire [31:0] wd, rdat;
  always #2.5 clk = ~clk;
  rcr_ahb_master m (.i_clk(clk), .i_hready(rdy), .i_hrdata(rdat),
    .o_hsel(sel), .o_hwrite(wen), .o_htrans(tr), .o_hsize(sz),
    .o_haddr(ad), .o_hwdata(wd));
  // request lines: 0 pin (low active), 1 power-on, 2 watchdog, 3 volts
  rcr_top dut (.I_CLK(clk), .I_ARST_N(rst_n), .I_CE(1'b1),
    .I_RST_PIN_N(~req[0]), .I_POC_REQ(req[1]), .I_WDT_REQ(req[2]),
    .I_LVD_REQ(req[3]), .I_HSEL(sel), .I_HADDR(ad), .I_HTRANS(tr),
    .I_HWRITE(wen), .I_HSIZE(sz), .I_HWDATA(wd), .I_HREADY(rdy),
    .O_HRDATA(rdat), .O_HREADYOUT(rdy), .O_HRESP(resp), .O_IRQ(irq),
    .O_LVD_CTRL(ctl), .O_LVD_LEVEL(lvl), .O_PC_VALID(pcv),
    .O_IN_RESET(inr));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input string n);
    logic [31:0] d;
    m.xfer(a, 1'b0, 32'h0, d);
    chk(n, e, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    m.xfer(a, 1'b1, v, d);
  endtask
  // one request held until seen, then the oscillator wait is timed
  task automatic pulse(input int s);
    int n;
    n = 0;
    req[s] <= 1'b1;
    while (inr !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("in_reset_on", 1, inr);
    chk("pc_in_reset", 0, pcv);
    req[s] <= 1'b0;
    n = 0;
    while (inr !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("in_reset_off", 0, inr);
    n = 0;
    while (pcv !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("osc_wait", 1, n >= 19 && n <= 22);
  endtask
  //////////////////////////////////////////////////////////////////////
  // power-up values, a read-only write and an unmapped read
  task automatic t_reset;
    chk("pc_idle", 1, pcv);
    rd(8'h00, 0, "cause");
    rd(8'h04, 0, "ctrl");
    rd(8'h08, 0, "level");
    rd(8'h10, 0, "mask");
    rd(8'h14, 32'h2, "status_idle");
    rd(8'h18, 0, "last_none");
    wr(8'h00, 32'h11);
    rd(8'h00, 0, "cause_ro");
    rd(8'h1c, 0, "unmapped");
    chk("resp", 0, resp);
  endtask
  // watchdog sets its flag, clears control; a read clears the flags
  task automatic t_wdt;
    wr(8'h04, 32'h5a);
    wr(8'h08, 32'h3c);
    pulse(2);
    rd(8'h00, 32'h10, "cause_wdt");
    rd(8'h04, 0, "ctrl_wdt");
    rd(8'h08, 0, "level_wdt");
    chk("ctrl_out_wdt", 0, ctl);
    rd(8'h18, 32'h3, "last_wdt");
    rd(8'h00, 0, "cause_rdclr");
  endtask
  // low voltage sets its flag, keeps watchdog flag and control
  task automatic t_lvd;
    pulse(2);
    wr(8'h04, 32'ha5);
    wr(8'h08, 32'hc3);
    pulse(3);
    rd(8'h00, 32'h11, "cause_lvd");
    rd(8'h04, 32'ha5, "ctrl_lvd");
    rd(8'h08, 32'hc3, "level_lvd");
    chk("ctrl_out_lvd", 32'ha5, ctl);
    chk("level_out_lvd", 32'hc3, lvl);
    rd(8'h18, 32'h4, "last_lvd");
  endtask
  // pin and power-on clear flags and control; watchdog keeps volts flag
  task automatic t_clear;
    for (int s = 0; s < 2; s++) begin
      pulse(3);
      pulse(2);
      rd(8'h00, 32'h11, "cause_both");
      // the read above cleared the flags: set both again before the clear
      pulse(2);
      pulse(3);
      wr(8'h04, 32'h77);
      wr(8'h08, 32'h66);
      pulse(s);
      rd(8'h00, 0, "cause_clr");
      rd(8'h04, 0, "ctrl_clr");
      rd(8'h08, 0, "level_clr");
      rd(8'h18, s + 1, "last_clr");
    end
  endtask
  // interrupt raised, cleared by read, and masked
  task automatic t_irq;
    rd(8'h0c, 32'hf, "irq_all");
    rd(8'h0c, 0, "irq_clr");
    wr(8'h10, 32'h4);
    pulse(2);
    chk("irq_on", 1, irq);
    rd(8'h0c, 32'h4, "irq_wdt");
    repeat (2) @(posedge clk);
    chk("irq_off", 0, irq);
    pulse(3);
    chk("irq_masked", 0, irq);
    rd(8'h0c, 32'h8, "irq_lvd");
  endtask
  task automatic test_done;
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // flops launched at the first edge are read one edge later
    repeat (2) @(posedge clk);
    t_reset();
    t_wdt();
    t_lvd();
    t_clear();
    t_irq();
    test_done();
  end
  // the whole run needs well under a fifth of this span
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
endmodule // reset_cause_recorder_bench
